//--- timer_ctl_map.vh
// Register offsets, field positions, reset values and clock codes of the ten-bit timer.
`ifndef TIMER_CTL_MAP_VH
`define TIMER_CTL_MAP_VH

// Register addresses on the plain register port.
`define ADDR_W              4
`define OFF_CONTROL_ZERO    4'h0
`define OFF_CONTROL_ONE     4'h1
`define OFF_COUNT_LOW       4'h2
`define OFF_COUNT_HIGH      4'h3
`define OFF_STATUS          4'h4

// Reset values of the two control registers.
`define RST_CONTROL_ZERO    8'h00
`define RST_CONTROL_ONE     8'h00

// Field positions in the first control register.
`define F_PAUSE             7
`define F_CLKSEL_HI         6
`define F_CLKSEL_LO         4
`define F_RUN               3
`define F_PERIOD_HI         2
`define F_PERIOD_LO         0

// Field positions in the second control register.
`define F_MODE_HI           7
`define F_MODE_LO           6
`define F_OUTFN_HI          5
`define F_OUTFN_LO          4
`define F_INIT_LEVEL        3
`define F_POLARITY          2
`define F_DUTY_SWAP         1
`define F_CLEAR_SEL         0

// Operating mode codes.
`define MODE_COMPARE        2'h0

// Count clock select codes.
`define CK_SYS_DIV4         3'h0
`define CK_SYS              3'h1
`define CK_HI_DIV16         3'h2
`define CK_HI_DIV64         3'h3
`define CK_TIME_BASE        3'h4
`define CK_RESERVED         3'h5
`define CK_PIN_RISE         3'h6
`define CK_PIN_FALL         3'h7

// Divider terminal counts.
`define DIV4_LAST           2'h3
`define DIV16_LAST          4'hF
`define DIV64_LAST          6'h3F

// Counter geometry.
`define CNT_W               10
`define PERIOD_W            3
`define PERIOD_LSB          7

`endif

//--- count_tick_gen.v
// Count clock source selection that turns the chosen source into one-cycle count events.
`timescale 1ns/10ps
`include "timer_ctl_map.vh"

module count_tick_gen (
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    input  wire [2:0] count_clock_select_in,
    input  wire       high_clk_tick_in,
    input  wire       time_base_tick_in,
    input  wire       external_count_clock_pin_in,
    output reg        count_tick_out
);

    reg  [1:0] sys_div_q;
    reg  [5:0] hi_div_q;
    reg        pin_s1_q;
    reg        pin_s2_q;
    reg        pin_s3_q;
    reg        pin_level_q;
    wire       pin_change;

    // Free-running system clock divider by four.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_div_q <= 2'h0;
        end else begin
            sys_div_q <= sys_div_q + 2'h1;
        end
    end

    // High clock prescaler, advanced by each high clock event.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_div_q <= 6'h00;
        end else if (high_clk_tick_in) begin
            hi_div_q <= hi_div_q + 6'h01;
        end
    end

    // Pin synchroniser; the level is accepted once stages two and three agree.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s1_q    <= 1'b0;
            pin_s2_q    <= 1'b0;
            pin_s3_q    <= 1'b0;
            pin_level_q <= 1'b0;
        end else begin
            pin_s1_q <= external_count_clock_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) begin
                pin_level_q <= pin_s3_q;
            end
        end
    end

    assign pin_change = (pin_s2_q == pin_s3_q) && (pin_s3_q != pin_level_q);

    // Source selection; the reserved code never produces an event.
    always @* begin
        case (count_clock_select_in)
            `CK_SYS_DIV4:  count_tick_out = (sys_div_q == `DIV4_LAST);
            `CK_SYS:       count_tick_out = 1'b1;
            `CK_HI_DIV16:  count_tick_out = high_clk_tick_in && (hi_div_q[3:0] == `DIV16_LAST);
            `CK_HI_DIV64:  count_tick_out = high_clk_tick_in && (hi_div_q == `DIV64_LAST);
            `CK_TIME_BASE: count_tick_out = time_base_tick_in;
            `CK_PIN_RISE:  count_tick_out = pin_change && pin_s3_q;
            `CK_PIN_FALL:  count_tick_out = pin_change && !pin_s3_q;
            default:       count_tick_out = 1'b0;
        endcase
    end

endmodule // count_tick_gen

//--- ten_bit_timer_period_control.v
// Control registers, ten-bit counter, period compare and output level of the timer.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "timer_ctl_map.vh"

module ten_bit_timer_period_control (
    input  wire               core_clk_in,
    input  wire               rst_n_in,
    input  wire [`ADDR_W-1:0] reg_addr_in,
    input  wire [7:0]         reg_wdata_in,
    input  wire               reg_wr_in,
    input  wire               reg_rd_in,
    output reg  [7:0]         reg_rdata_out,
    input  wire               high_clk_tick_in,
    input  wire               time_base_tick_in,
    input  wire               external_count_clock_pin_in,
    output reg  [9:0]         count_value_out,
    output reg                period_match_out,
    output reg                timer_output_out,
    output reg                timer_powered_out
);

    // Control register storage.
    // The first register holds pause, clock select,
    // run enable and the period field.
    // The second holds mode, output function, initial
    // level, polarity, duty swap and clear select.
    // Only part of the second register acts here; the
    // rest is kept so software reads back its writes.
    reg  [7:0] timer_control_zero_q;
    reg  [7:0] timer_control_one_q;

    // Counter state.
    // The counter and its next value are kept apart
    // so one next value feeds both the counter and
    // the registered copy on the output port.
    // That copy therefore never lags the counter.
    // The previous run enable finds the switch-on edge.
    reg  [9:0] count_q;
    reg  [9:0] count_d;
    reg        run_prev_q;
    reg        match_d;

    // Output pin level.
    // Only the restore on switch-on is handled here.
    // Moving the level on a compare match belongs to
    // the comparator that owns the match.
    reg        out_level_q;
    reg        out_level_d;

    // Decoded control fields.
    // Each field gets its own name so the logic below
    // reads in terms of what a bit does, not where it
    // sits in a register.
    wire       counter_pause;
    wire [2:0] count_clock_select;
    wire       counter_run_enable;
    wire [2:0] period_compare_field;
    wire       op_mode_hi;
    wire       op_mode_lo;
    wire       output_initial_level;
    wire       counter_clear_select;

    // Internal events.
    // All of these are combinational conditions on the
    // core clock.
    // None needs a synchroniser: the pin is already
    // filtered inside the tick generator.
    wire       count_tick;
    wire       run_rise;
    wire       clock_halted;
    wire       advance;
    wire [9:0] count_next;

    // Returns one when the top three counter bits equal the period field.
    // Only bits nine to seven take part, so match
    // points fall on whole multiples of 128 events.
    // The low bits are judged by the next function.
    function period_hit;
        input [9:0] value;
        input [2:0] field;
        begin
            period_hit = (value[`CNT_W-1:`PERIOD_LSB] == field);
        end
    endfunction

    // Returns one when the low counter bits sit on a 128-count boundary.
    // With the compare above this picks the first
    // count of the matching span, so a match lasts
    // exactly one count event.
    function on_boundary;
        input [9:0] value;
        begin
            on_boundary = (value[`PERIOD_LSB-1:0] == 7'h00);
        end
    endfunction

    // Field extraction from the control registers.
    // Whatever starts, stops or paces the counter
    // comes from the first register.
    // Mode bits, initial level and clear select come
    // from the second.
    assign counter_pause        = timer_control_zero_q[`F_PAUSE];
    assign count_clock_select   = timer_control_zero_q[`F_CLKSEL_HI:`F_CLKSEL_LO];
    assign counter_run_enable   = timer_control_zero_q[`F_RUN];
    assign period_compare_field = timer_control_zero_q[`F_PERIOD_HI:`F_PERIOD_LO];
    assign op_mode_hi           = timer_control_one_q[`F_MODE_HI];
    assign op_mode_lo           = timer_control_one_q[`F_MODE_LO];
    assign output_initial_level = timer_control_one_q[`F_INIT_LEVEL];
    assign counter_clear_select = timer_control_one_q[`F_CLEAR_SEL];

    // Count event source, selected by the clock select field.
    // The generator gives the counter one enable per
    // event; the system clock code holds it high every
    // cycle and the time base tick passes straight through.
    // The external pin is synchronised inside it.
    // Expect three to four cycles between a pin edge
    // and the count it causes.
    count_tick_gen u_count_tick_gen (
        .core_clk_in                 (core_clk_in),
        .rst_n_in                    (rst_n_in),
        .count_clock_select_in       (count_clock_select),
        .high_clk_tick_in            (high_clk_tick_in),
        .time_base_tick_in           (time_base_tick_in),
        .external_count_clock_pin_in (external_count_clock_pin_in),
        .count_tick_out              (count_tick)
    );

    // The reserved code leaves the counter idle even though it stays enabled.
    // The generator already gives no event for it.
    // This term keeps the counter still even if the
    // generator's decoding is ever changed.
    assign clock_halted = (count_clock_select == `CK_RESERVED);

    // A rising run enable is seen one cycle after the register write lands.
    // In that cycle the counter is loaded with zero
    // instead of advancing.
    // A count event landing in that very cycle is
    // dropped; the run starts from zero on the next.
    assign run_rise = counter_run_enable && !run_prev_q;

    // Counting needs run enable, no pause, a live clock code and an event.
    // Pause and switch-off both stop the count.
    // Only switch-off drops the powered flag; a
    // paused timer stays powered.
    // The reserved code stops it but keeps power.
    assign advance = counter_run_enable && !counter_pause && !clock_halted
                     && count_tick;

    // Incremented counter; wraps from 1023 to 0 on its own.
    // The wrap gives the 1024-event period of code
    // zero without any extra compare.
    assign count_next = count_q + 10'h001;

    // Software writes to the two control registers.
    // A write lands at the edge that carries the
    // strobe.
    // Writes to the counter, status or unmapped
    // addresses are ignored.
    // Switch the timer off before changing the mode
    // bits; a change under a running count is unguarded.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_control_zero_q <= `RST_CONTROL_ZERO;
            timer_control_one_q  <= `RST_CONTROL_ONE;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `OFF_CONTROL_ZERO) begin
                timer_control_zero_q <= reg_wdata_in;
            end
            if (reg_addr_in == `OFF_CONTROL_ONE) begin
                timer_control_one_q <= reg_wdata_in;
            end
        end
    end

    // Previous run enable, used to find its rising edge.
    // Reset leaves it low, like run enable itself, so
    // no false switch-on follows reset.
    // It runs every cycle, paused or not.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= counter_run_enable;
        end
    end

    // Next counter value and period match.
    // The match point is reached when the incremented value lands on
    // code times 128; code zero therefore matches on the wrap at 1024.
    // Switch-on has priority over counting.
    // A clearing match takes the place of the
    // increment in the same cycle.
    // With clear select high the match is still
    // flagged, but the counter runs on and wraps.
    // A period code changed mid-run acts at once.
    always @* begin
        count_d = count_q;
        match_d = 1'b0;
        if (run_rise) begin
            count_d = 10'h000;
        end else if (advance) begin
            count_d = count_next;
            if (period_hit(count_next, period_compare_field)
                && on_boundary(count_next)) begin
                match_d = 1'b1;
                if (!counter_clear_select) begin
                    count_d = 10'h000;
                end
            end
        end
        // With run enable low, paused or halted, the value is simply kept.
    end

    // Counter register; holds while off so its residual value stays readable.
    // Pause and the reserved code hold it the same
    // way.
    // Only reset, switch-on, a clearing match and the wrap
    // from 1023 bring it back to zero.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= 10'h000;
        end else begin
            count_q <= count_d;
        end
    end

    // Output level: restored to the initial level when compare mode starts.
    // Other output functions are driven by the compare logic elsewhere.
    // In capture, pulse or counter modes switch-on
    // leaves the level alone.
    always @* begin
        out_level_d = out_level_q;
        if (run_rise && ({op_mode_hi, op_mode_lo} == `MODE_COMPARE)) begin
            out_level_d = output_initial_level;
        end
    end

    // Output level register.
    // Reset drives the level low until the first
    // switch-on in compare mode.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_level_q <= 1'b0;
        end else begin
            out_level_q <= out_level_d;
        end
    end

    // Registered top-level outputs.
    // Every port is a flip-flop, so nothing
    // combinational reaches the pins.
    // Count and match take the next values and so
    // agree with the counter.
    // The powered flag lags run enable by one cycle.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_value_out   <= 10'h000;
            period_match_out  <= 1'b0;
            timer_output_out  <= 1'b0;
            timer_powered_out <= 1'b0;
        end else begin
            count_value_out   <= count_d;
            period_match_out  <= match_d;
            timer_output_out  <= out_level_d;
            timer_powered_out <= counter_run_enable;
        end
    end

    // Read data, valid in the cycle after the read strobe only.
    // Outside that cycle the port returns zero, so a
    // stale value is never taken for a fresh read.
    // The counter bytes are not latched together:
    // read low then high only while the count is
    // stopped or paused.
    // Status gives the reserved-code halt, the
    // advance of this cycle and the output level.
    // Unmapped addresses read as zero.
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `OFF_CONTROL_ZERO: reg_rdata_out <= timer_control_zero_q;
                `OFF_CONTROL_ONE:  reg_rdata_out <= timer_control_one_q;
                `OFF_COUNT_LOW:    reg_rdata_out <= count_q[7:0];
                `OFF_COUNT_HIGH:   reg_rdata_out <= {6'h00, count_q[9:8]};
                `OFF_STATUS:       reg_rdata_out <= {5'h00, clock_halted,
                                                     advance, out_level_q};
                default:           reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

endmodule // ten_bit_timer_period_control

//--- timer_ctl_chk.sv
// Assertion checker for the ten-bit timer control ports.
`timescale 1ns/10ps
module timer_ctl_chk (
    input logic       core_clk_in,
    input logic       rst_n_in,
    input logic [3:0] reg_addr_in,
    input logic [7:0] reg_wdata_in,
    input logic       reg_wr_in,
    input logic [9:0] count_value_out,
    input logic       period_match_out,
    input logic       timer_output_out,
    input logic       timer_powered_out
);
    logic [7:0] sh0_q;
    logic [7:0] sh1_q;
    wire  [9:0] last_w = {sh0_q[2:0], 7'h00} - 10'h001;

    // Shadow copies of both control registers follow the bus writes.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sh0_q <= 8'h00;
            sh1_q <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == 4'h0)
                sh0_q <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 4'h1)
                sh1_q <= reg_wdata_in;
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Three settled cycles are needed so a tick already in flight cannot fire.
    sequence s_paused;
        (sh0_q[7] && timer_powered_out) [*3];
    endsequence
    sequence s_halted;
        (sh0_q[6:4] == 3'h5 && timer_powered_out) [*3];
    endsequence
    sequence s_start;
        $rose(timer_powered_out);
    endsequence

    a_run_clear: assert property (s_start |-> count_value_out == 10'h000)
        else $error("counter not cleared when run started");
    a_run_level: assert property ($rose(timer_powered_out) && sh1_q[7:6] == 2'h0
        |-> timer_output_out == sh1_q[3])
        else $error("output not restored to its initial level");
    a_off_hold: assert property (!timer_powered_out && !$past(timer_powered_out)
        |-> $stable(count_value_out))
        else $error("counter moved while switched off");
    a_power_follow: assert property (timer_powered_out == $past(sh0_q[3]))
        else $error("power state does not follow run enable");
    a_step_one: assert property ($changed(count_value_out) |-> count_value_out == 10'h000
        || count_value_out == $past(count_value_out) + 10'h001)
        else $error("counter stepped by more than one");
    a_match_point: assert property (period_match_out
        |-> $past(count_value_out) == last_w)
        else $error("period match at the wrong count");
    a_match_clear: assert property (period_match_out && !sh1_q[0]
        |-> count_value_out == 10'h000)
        else $error("period match did not clear the counter");
    a_halt_hold: assert property (s_halted |-> $stable(count_value_out))
        else $error("counter moved on the reserved clock code");
    a_pause_hold: assert property (s_paused |-> $stable(count_value_out))
        else $error("counter moved while paused");
endmodule // timer_ctl_chk

//--- ext_pin_model.sv
// Model of the external count clock pin that drives bursts of edges.
`timescale 1ns/10ps
module ext_pin_model (
    input  logic core_clk_in,
    output logic ext_pin_out
);
    // The pin idles low and moves on falling clock edges, as an unrelated source would.
    initial ext_pin_out = 1'b0;
    task automatic burst(input int n);
        repeat (n) begin
            repeat (5) @(negedge core_clk_in);
            ext_pin_out = 1'b1;
            repeat (5) @(negedge core_clk_in);
            ext_pin_out = 1'b0;
        end
    endtask
endmodule // ext_pin_model

//--- tb.sv
// Self-checking bench for the ten-bit timer control block.
`timescale 1ns/10ps
`include "timer_ctl_map.vh"
module tb;
    logic               core_clk_in       = 1'b0;
    logic               rst_n_in          = 1'b0;
    logic [`ADDR_W-1:0] reg_addr_in       = 4'h0;
    logic [7:0]         reg_wdata_in      = 8'h00;
    logic               reg_wr_in         = 1'b0;
    logic               reg_rd_in         = 1'b0;
    logic               high_clk_tick_in  = 1'b0;
    logic               time_base_tick_in = 1'b0;
    logic [7:0]         seed              = 8'h44;
    logic [7:0]         reg_rdata_out;
    logic [9:0]         count_value_out;
    logic               period_match_out;
    logic               timer_output_out;
    logic               timer_powered_out;
    wire                pin_w;
    logic [7:0]         b;
    logic [9:0]         v;
    logic [9:0]         w;
    logic [2:0]         c;
    logic               lvl;
    int                 miscompares = 0;
    int                 checks_done = 0;
    int                 ticks = 0;
    int                 t0;
    int                 n;
    int                 e;

    ten_bit_timer_period_control i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .high_clk_tick_in(high_clk_tick_in), .time_base_tick_in(time_base_tick_in),
        .external_count_clock_pin_in(pin_w), .count_value_out(count_value_out),
        .period_match_out(period_match_out), .timer_output_out(timer_output_out),
        .timer_powered_out(timer_powered_out));
    ext_pin_model i_pin (.core_clk_in(core_clk_in), .ext_pin_out(pin_w));

    function automatic logic [7:0] next_rand(input logic [7:0] s);
        next_rand = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    always #5 core_clk_in = ~core_clk_in;

    // High clock ticks every other cycle; time base ticks come from the shift register.
    always @(posedge core_clk_in) begin
        seed <= next_rand(seed);
        high_clk_tick_in <= ~high_clk_tick_in;
        time_base_tick_in <= seed[0];
        ticks <= ticks + int'(time_base_tick_in);
    end

    task automatic check(input logic [10:0] got, input logic [10:0] exp, input int tol);
        checks_done++;
        if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
            miscompares++;
            $display("Error at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic rd_count(output logic [9:0] cnt);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(4'h2, lo);
        rd(4'h3, hi);
        cnt = {hi[1:0], lo};
    endtask
    task automatic wait_match(output int k);
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (period_match_out !== 1'b1 && k < 1100);
    endtask
    task automatic stop_test;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence: reset values, clock sources, halt, stop, pin edges, periods.
    initial begin
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        rd(4'h0, b);
        check(b, 0, 0);
        rd(4'h1, b);
        check(b, 0, 0);
        rd(4'hF, b);
        check(b, 0, 0);
        for (e = 0; e < 5; e++) begin
            c = e[2:0];
            wr(4'h0, {1'b0, c, 4'h0});
            t0 = ticks;
            wr(4'h0, {1'b0, c, 4'h8});
            repeat (512) @(posedge core_clk_in);
            wr(4'h0, {1'b1, c, 4'h8});
            n = (e == 0) ? 128 : (e == 1) ? 513 : (e == 2) ? 16 : (e == 3) ? 4 : ticks - t0;
            rd_count(v);
            check(v, n, 4);
            repeat (20) @(posedge core_clk_in);
            rd_count(w);
            check(w, v, 0);
        end
        wr(4'h0, 8'h50);
        wr(4'h0, 8'h58);
        repeat (20) @(posedge core_clk_in);
        rd_count(v);
        check(v, 0, 0);
        rd(4'h4, b);
        check(b, 8'h04, 0);
        wr(4'h0, 8'h18);
        repeat (40) @(posedge core_clk_in);
        wr(4'h0, 8'h10);
        rd_count(v);
        repeat (20) @(posedge core_clk_in);
        rd_count(w);
        check(w, v, 0);
        for (e = 0; e < 2; e++) begin
            wr(4'h0, {3'h3, e[0], 4'h0});
            wr(4'h0, {3'h3, e[0], 4'h8});
            n = int'(seed[3:0]) + 1;
            i_pin.burst(n);
            repeat (10) @(posedge core_clk_in);
            rd_count(v);
            check(v, n, 0);
        end
        for (e = 1; e < 9; e++) begin
            c = e[2:0];
            lvl = seed[1];
            wr(4'h1, {4'h0, lvl, 3'h0});
            wr(4'h0, {5'h02, c});
            wr(4'h0, {5'h03, c});
            @(posedge core_clk_in);
            #1 check(timer_output_out, lvl, 0);
            wait_match(n);
            wait_match(n);
            check(n, (c == 3'h0) ? 1024 : e * 128, 0);
        end
        stop_test();
    end

    // Watchdog cuts a hang short well beyond the expected run length.
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule // tb

bind ten_bit_timer_period_control timer_ctl_chk i_chk (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .count_value_out(count_value_out),
    .period_match_out(period_match_out), .timer_output_out(timer_output_out),
    .timer_powered_out(timer_powered_out));
